/* core/hsdac_pkg.sv */
// Shared constants and types for the high-speed DAC write and readback slave
package hsdac_pkg;
  localparam int CHANNELS = 4;
  localparam int FIFO_DEPTH = 32;
  localparam logic [4:0] ADDR_PREFIX = 5'h13;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;
  localparam logic [5:0] PD_FILL = 6'h3f;
  localparam logic [3:0] LOW_PAD = 4'h0;
  localparam logic [1:0] NORMAL_PD = 2'h0;
  localparam logic [13:0] HOLD_RESET = 14'h0000;
  localparam int CTRL_LOAD_POS = 4;
  localparam int CTRL_SEL_POS = 1;
  localparam int CTRL_KIND_POS = 0;
  localparam int PD_POS = 12;
  localparam int HIGH_PD_POS = 6;
  localparam int LOW_SAMPLE_POS = 4;
  localparam logic [1:0] TX_FIRST_PD = 2'h0;
  localparam logic [1:0] TX_FIRST_DATA = 2'h1;
  localparam logic [1:0] TX_LAST = 2'h2;

  typedef logic [13:0] hsdac_hold_type;

  typedef enum logic [1:0] {
    LOAD_HOLD = 2'h0,
    LOAD_ONE = 2'h1,
    LOAD_ALL = 2'h2,
    LOAD_BCAST = 2'h3
  } hsdac_load_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_CTRL = 4'h2,
    ST_CTRL_ACK = 4'h6,
    ST_RXD = 4'h7,
    ST_RXD_ACK = 4'h5,
    ST_TXD = 4'h4,
    ST_TXD_ACK = 4'hc
  } hsdac_link_state_type;

  typedef struct packed {
    logic [1:0] channel;
    hsdac_load_type load;
    logic data_kind_select;
    hsdac_hold_type value;
  } hsdac_word_type;

  typedef struct packed {
    hsdac_link_state_type state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic sda_oe_n;
    logic sda_level;
    logic rw;
    logic [1:0] channel;
    hsdac_load_type load;
    logic data_kind_select;
    logic low_phase;
    logic [7:0] high_byte;
    logic [1:0] tx_idx;
    logic ack_ok;
    logic scl_q;
    logic sda_q;
    logic req;
    hsdac_word_type word;
    hsdac_hold_type [3:0] shadow;
  } hsdac_link_type;

  typedef struct packed {
    logic ack;
    hsdac_hold_type [3:0] channel_holding_register;
    hsdac_hold_type [3:0] channel_output_register;
    logic [3:0] strobe;
  } hsdac_sys_type;
endpackage : hsdac_pkg

/* core/hsdac_sync.sv */
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module hsdac_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Signals
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] ff1;
  logic [WIDTH-1:0] ff2;
  logic [WIDTH-1:0] ff3;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ff1 <= '0;
      ff2 <= '0;
      ff3 <= '0;
      sync_out <= '0;
    end else begin
      ff1 <= async_in;
      ff2 <= ff1;
      ff3 <= ff2;
      sync_out <= (ff2 & ff3) | (sync_out & (ff2 ^ ff3));
    end
  end
endmodule : hsdac_sync

/* core/hsdac_fifo.sv */
// Synchronous word FIFO with valid and ready on both sides
`timescale 1ns/1ps
module hsdac_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // Drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready_out = (wr_ptr - rd_ptr) != FULL_COUNT;
  assign out_valid_out = wr_ptr != rd_ptr;
  assign out_data_out = mem[rd_ptr[AW-1:0]];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end
endmodule : hsdac_fifo

/* core/hsdac_slave.sv */
// Two-wire slave receive and readback path of a quad 12-bit converter
`timescale 1ns/1ps
module hsdac_slave (
  // Clocks and reset
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic LINK_CLK_IN,
  // Two-wire pins
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N_OUT,
  // Address pins
  input wire logic ADDRESS_PIN_HI_IN,
  input wire logic ADDRESS_PIN_LO_IN,
  // Converter side
  input wire logic UPDATE_HOLD_IN,
  output hsdac_pkg::hsdac_hold_type [3:0] CHANNEL_HOLDING_REGISTER_OUT,
  output hsdac_pkg::hsdac_hold_type [3:0] CHANNEL_OUTPUT_REGISTER_OUT,
  output logic [3:0] UPDATE_STROBE_OUT
);
  hsdac_pkg::hsdac_link_type link;
  hsdac_pkg::hsdac_link_type next_link;
  hsdac_pkg::hsdac_sys_type sys;
  hsdac_pkg::hsdac_sys_type next_sys;
  hsdac_pkg::hsdac_word_type fifo_word;
  logic [4:0] link_s;
  logic [1:0] sys_s;
  logic pin_scl;
  logic pin_sda;
  logic [1:0] pin_addr;
  logic ack_s;
  logic req_s;
  logic hold_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic busy;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] tx_first;
  logic [7:0] tx_next;
  logic [1:0] first_idx;
  logic [1:0] next_idx;
  hsdac_pkg::hsdac_hold_type cur_value;
  hsdac_pkg::hsdac_hold_type new_value;

  // Transmit byte for a readback position
  function automatic logic [7:0] tx_byte(
    input logic [1:0] idx,
    input hsdac_pkg::hsdac_hold_type value
  );
    logic [7:0] b;
    b = {value[3:0], hsdac_pkg::LOW_PAD};
    if (idx == hsdac_pkg::TX_FIRST_PD) begin
      b = {value[hsdac_pkg::PD_POS +: 2], hsdac_pkg::PD_FILL};
    end else if (idx == hsdac_pkg::TX_FIRST_DATA) begin
      b = value[11:4];
    end
    return b;
  endfunction : tx_byte

  // Pin and cross-domain synchronisers, link side
  hsdac_sync #(
    .WIDTH(5)
  ) u_link_sync (
    .clk_in(LINK_CLK_IN),
    .rst_in(SYS_RST_IN),
    .async_in({sys.ack, ADDRESS_PIN_HI_IN, ADDRESS_PIN_LO_IN, SCL_IN,
               SDA_IN}),
    .sync_out(link_s)
  );

  // Pin and cross-domain synchronisers, system side
  hsdac_sync #(
    .WIDTH(2)
  ) u_sys_sync (
    .clk_in(SYS_CLK_IN),
    .rst_in(SYS_RST_IN),
    .async_in({UPDATE_HOLD_IN, link.req}),
    .sync_out(sys_s)
  );

  assign ack_s = link_s[4];
  assign pin_addr = link_s[3:2];
  assign pin_scl = link_s[1];
  assign pin_sda = link_s[0];
  assign hold_s = sys_s[1];
  assign req_s = sys_s[0];

  assign scl_rise = pin_scl && !link.scl_q;
  assign scl_fall = !pin_scl && link.scl_q;
  assign start_seen = pin_scl && link.scl_q && link.sda_q && !pin_sda;
  assign stop_seen = pin_scl && link.scl_q && !link.sda_q && pin_sda;
  assign busy = link.req != ack_s;

  assign cur_value = link.shadow[link.channel];
  assign first_idx = link.data_kind_select ? hsdac_pkg::TX_FIRST_PD :
                     hsdac_pkg::TX_FIRST_DATA;
  assign next_idx = link.tx_idx + 2'h1;
  assign tx_first = tx_byte(first_idx, cur_value);
  assign tx_next = tx_byte(next_idx, cur_value);

  // Value of a completed pair
  always_comb begin
    if (link.data_kind_select) begin
      new_value = {link.high_byte[hsdac_pkg::HIGH_PD_POS +: 2],
                   cur_value[11:0]};
    end else begin
      new_value = {hsdac_pkg::NORMAL_PD, link.high_byte,
                   link.shreg[hsdac_pkg::LOW_SAMPLE_POS +: 4]};
    end
  end

  // Link protocol engine
  always_comb begin
    next_link = link;
    next_link.scl_q = pin_scl;
    next_link.sda_q = pin_sda;
    next_link.sda_level = 1'b0;
    if (start_seen) begin
      next_link.state = hsdac_pkg::ST_ADDR;
      next_link.bit_cnt = hsdac_pkg::BIT_CNT_RESET;
      next_link.sda_oe_n = 1'b1;
    end else if (stop_seen) begin
      next_link.state = hsdac_pkg::ST_IDLE;
      next_link.sda_oe_n = 1'b1;
    end else if (scl_rise) begin
      if (link.state == hsdac_pkg::ST_ADDR ||
          link.state == hsdac_pkg::ST_CTRL ||
          link.state == hsdac_pkg::ST_RXD) begin
        next_link.shreg = {link.shreg[6:0], pin_sda};
        next_link.bit_cnt = link.bit_cnt + 4'h1;
      end else if (link.state == hsdac_pkg::ST_TXD) begin
        next_link.bit_cnt = link.bit_cnt + 4'h1;
      end else if (link.state == hsdac_pkg::ST_TXD_ACK) begin
        next_link.ack_ok = !pin_sda;
      end
    end else if (scl_fall) begin
      unique case (link.state)
        hsdac_pkg::ST_IDLE: begin
          next_link.sda_oe_n = 1'b1;
        end
        hsdac_pkg::ST_ADDR: begin
          if (link.bit_cnt == hsdac_pkg::BYTE_BITS) begin
            if (link.shreg[7:1] == {hsdac_pkg::ADDR_PREFIX, pin_addr}) begin
              next_link.sda_oe_n = 1'b0;
              next_link.rw = link.shreg[0];
              next_link.state = hsdac_pkg::ST_ADDR_ACK;
            end else begin
              next_link.state = hsdac_pkg::ST_IDLE;
            end
          end
        end
        hsdac_pkg::ST_ADDR_ACK: begin
          next_link.bit_cnt = hsdac_pkg::BIT_CNT_RESET;
          if (link.rw) begin
            next_link.state = hsdac_pkg::ST_TXD;
            next_link.tx_idx = first_idx;
            next_link.shreg = tx_first;
            next_link.sda_oe_n = tx_first[7];
          end else begin
            next_link.state = hsdac_pkg::ST_CTRL;
            next_link.sda_oe_n = 1'b1;
          end
        end
        hsdac_pkg::ST_CTRL: begin
          if (link.bit_cnt == hsdac_pkg::BYTE_BITS) begin
            next_link.channel = link.shreg[hsdac_pkg::CTRL_SEL_POS +: 2];
            next_link.load = hsdac_pkg::hsdac_load_type'(
              link.shreg[hsdac_pkg::CTRL_LOAD_POS +: 2]);
            next_link.data_kind_select =
              link.shreg[hsdac_pkg::CTRL_KIND_POS];
            next_link.sda_oe_n = 1'b0;
            next_link.state = hsdac_pkg::ST_CTRL_ACK;
          end
        end
        hsdac_pkg::ST_CTRL_ACK: begin
          next_link.sda_oe_n = 1'b1;
          next_link.bit_cnt = hsdac_pkg::BIT_CNT_RESET;
          next_link.low_phase = 1'b0;
          next_link.state = hsdac_pkg::ST_RXD;
        end
        hsdac_pkg::ST_RXD: begin
          if (link.bit_cnt == hsdac_pkg::BYTE_BITS) begin
            if (!link.low_phase) begin
              if (!busy) begin
                next_link.high_byte = link.shreg;
                next_link.sda_oe_n = 1'b0;
                next_link.state = hsdac_pkg::ST_RXD_ACK;
              end else begin
                next_link.state = hsdac_pkg::ST_IDLE;
              end
            end else begin
              next_link.word.channel = link.channel;
              next_link.word.load = link.load;
              next_link.word.data_kind_select = link.data_kind_select;
              next_link.word.value = new_value;
              if (link.load == hsdac_pkg::LOAD_BCAST) begin
                for (int i = 0; i < hsdac_pkg::CHANNELS; i++) begin
                  next_link.shadow[i] = new_value;
                end
              end else begin
                next_link.shadow[link.channel] = new_value;
              end
              next_link.req = !link.req;
              next_link.sda_oe_n = 1'b0;
              next_link.state = hsdac_pkg::ST_RXD_ACK;
            end
          end
        end
        hsdac_pkg::ST_RXD_ACK: begin
          next_link.sda_oe_n = 1'b1;
          next_link.bit_cnt = hsdac_pkg::BIT_CNT_RESET;
          next_link.low_phase = !link.low_phase;
          next_link.state = hsdac_pkg::ST_RXD;
        end
        hsdac_pkg::ST_TXD: begin
          if (link.bit_cnt == hsdac_pkg::BYTE_BITS) begin
            next_link.sda_oe_n = 1'b1;
            next_link.state = hsdac_pkg::ST_TXD_ACK;
          end else begin
            next_link.shreg = {link.shreg[6:0], 1'b0};
            next_link.sda_oe_n = link.shreg[6];
          end
        end
        hsdac_pkg::ST_TXD_ACK: begin
          if (link.ack_ok && link.tx_idx != hsdac_pkg::TX_LAST) begin
            next_link.tx_idx = next_idx;
            next_link.shreg = tx_next;
            next_link.sda_oe_n = tx_next[7];
            next_link.bit_cnt = hsdac_pkg::BIT_CNT_RESET;
            next_link.state = hsdac_pkg::ST_TXD;
          end else begin
            next_link.sda_oe_n = 1'b1;
            next_link.state = hsdac_pkg::ST_IDLE;
          end
        end
        default: begin
          next_link.sda_oe_n = 1'b1;
          next_link.state = hsdac_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge LINK_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      link <= '0;
      link.state <= hsdac_pkg::ST_IDLE;
      link.sda_oe_n <= 1'b1;
      link.shadow <= {hsdac_pkg::CHANNELS{hsdac_pkg::HOLD_RESET}};
    end else begin
      link <= next_link;
    end
  end

  // Word buffer between the link and the channel registers
  assign fifo_in_valid = req_s != sys.ack;
  assign fifo_out_ready = !hold_s;

  hsdac_fifo #(
    .WIDTH($bits(hsdac_pkg::hsdac_word_type)),
    .DEPTH(hsdac_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in(SYS_CLK_IN),
    .rst_in(SYS_RST_IN),
    .in_valid_in(fifo_in_valid),
    .in_data_in(link.word),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(fifo_out_valid),
    .out_data_out(fifo_word),
    .out_ready_in(fifo_out_ready)
  );

  // Channel holding and output registers
  always_comb begin
    next_sys = sys;
    next_sys.strobe = 4'h0;
    if (fifo_in_valid && fifo_in_ready) begin
      next_sys.ack = req_s;
    end
    if (fifo_out_valid && fifo_out_ready) begin
      unique case (fifo_word.load)
        hsdac_pkg::LOAD_HOLD: begin
          next_sys.channel_holding_register[fifo_word.channel] =
            fifo_word.value;
        end
        hsdac_pkg::LOAD_ONE: begin
          next_sys.channel_holding_register[fifo_word.channel] =
            fifo_word.value;
          next_sys.channel_output_register[fifo_word.channel] =
            fifo_word.value;
          next_sys.strobe[fifo_word.channel] = 1'b1;
        end
        hsdac_pkg::LOAD_ALL: begin
          next_sys.channel_holding_register[fifo_word.channel] =
            fifo_word.value;
          next_sys.channel_output_register =
            next_sys.channel_holding_register;
          next_sys.strobe = 4'hf;
        end
        hsdac_pkg::LOAD_BCAST: begin
          for (int i = 0; i < hsdac_pkg::CHANNELS; i++) begin
            next_sys.channel_holding_register[i] = fifo_word.value;
            next_sys.channel_output_register[i] = fifo_word.value;
          end
          next_sys.strobe = 4'hf;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      sys <= '0;
      sys.channel_holding_register <=
        {hsdac_pkg::CHANNELS{hsdac_pkg::HOLD_RESET}};
      sys.channel_output_register <=
        {hsdac_pkg::CHANNELS{hsdac_pkg::HOLD_RESET}};
    end else begin
      sys <= next_sys;
    end
  end

  // Outputs
  assign SDA_OUT = link.sda_level;
  assign SDA_OE_N_OUT = link.sda_oe_n;
  assign CHANNEL_HOLDING_REGISTER_OUT = sys.channel_holding_register;
  assign CHANNEL_OUTPUT_REGISTER_OUT = sys.channel_output_register;
  assign UPDATE_STROBE_OUT = sys.strobe;
endmodule : hsdac_slave

/* test/hsdac_mst.sv */
// Two-wire bus master model for the converter slave bench
`timescale 1ns/1ps
module hsdac_mst (
  // Link timing
  input wire logic clk_in,
  // Bus lines
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  task automatic q();
    repeat (4) @(posedge clk_in);
  endtask : q

  // Start or repeated start, from idle or mid-frame
  task automatic start();
    sda_low_out <= 1'b0;
    q();
    scl_out <= 1'b1;
    q();
    sda_low_out <= 1'b1;
    q();
    scl_out <= 1'b0;
    q();
  endtask : start

  task automatic stop();
    sda_low_out <= 1'b1;
    q();
    scl_out <= 1'b1;
    q();
    sda_low_out <= 1'b0;
    q();
  endtask : stop

  task automatic bit_x(input logic b, output logic s);
    sda_low_out <= !b;
    q();
    scl_out <= 1'b1;
    q();
    s = sda_in;
    q();
    scl_out <= 1'b0;
    q();
  endtask : bit_x

  task automatic wr(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(b[i], s);
    bit_x(1'b1, s);
    ack = !s;
  endtask : wr

  task automatic rd(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, s);
      b[i] = s;
    end
    bit_x(!more, s);
  endtask : rd
endmodule : hsdac_mst

/* test/hsdac_slave_sva.sv */
// Port-level assertions for the two-wire converter slave
`timescale 1ns/1ps
module hsdac_slave_sva (
  // Clocks and reset
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic LINK_CLK_IN,
  // Two-wire pins
  input wire logic SCL_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_N_OUT,
  // Converter side
  input wire logic UPDATE_HOLD_IN,
  input wire hsdac_pkg::hsdac_hold_type [3:0] CHANNEL_HOLDING_REGISTER_OUT,
  input wire hsdac_pkg::hsdac_hold_type [3:0] CHANNEL_OUTPUT_REGISTER_OUT,
  input wire logic [3:0] UPDATE_STROBE_OUT
);
  logic [55:0] mask;
  assign mask = {{14{UPDATE_STROBE_OUT[3]}}, {14{UPDATE_STROBE_OUT[2]}},
    {14{UPDATE_STROBE_OUT[1]}}, {14{UPDATE_STROBE_OUT[0]}}};

  AST_RESET_CLEAN: assert property (@(posedge SYS_CLK_IN)
    disable iff (SYS_RST_IN) $fell(SYS_RST_IN) |-> SDA_OE_N_OUT &&
    UPDATE_STROBE_OUT == 4'h0 && CHANNEL_OUTPUT_REGISTER_OUT == 56'h0 &&
    CHANNEL_HOLDING_REGISTER_OUT == 56'h0)
    else $error("state not clear after reset");
  AST_OUT_NEEDS_STROBE: assert property (@(posedge SYS_CLK_IN)
    disable iff (SYS_RST_IN)
    !$stable(CHANNEL_OUTPUT_REGISTER_OUT) |-> UPDATE_STROBE_OUT != 4'h0)
    else $error("output changed without strobe");
  AST_STROBE_COPIES: assert property (@(posedge SYS_CLK_IN)
    disable iff (SYS_RST_IN) UPDATE_STROBE_OUT != 4'h0 |->
    ((CHANNEL_OUTPUT_REGISTER_OUT ^ CHANNEL_HOLDING_REGISTER_OUT) & mask)
    == 56'h0)
    else $error("strobed output differs from holding");
  AST_HOLD_BLOCKS: assert property (@(posedge SYS_CLK_IN)
    disable iff (SYS_RST_IN)
    UPDATE_HOLD_IN [*8] |-> UPDATE_STROBE_OUT == 4'h0)
    else $error("update while held");
  AST_ACK_ON_LOW_CLOCK: assert property (@(posedge LINK_CLK_IN)
    disable iff (SYS_RST_IN) $fell(SDA_OE_N_OUT) |-> !SDA_OUT && !SCL_IN)
    else $error("data drive began outside clock low");
  AST_RELEASE_ON_LOW_CLOCK: assert property (@(posedge LINK_CLK_IN)
    disable iff (SYS_RST_IN) $rose(SDA_OE_N_OUT) |-> !SCL_IN)
    else $error("data released outside clock low");
  AST_ACK_HELD: assert property (@(posedge LINK_CLK_IN)
    disable iff (SYS_RST_IN)
    $fell(SCL_IN) && !SDA_OE_N_OUT |-> !SDA_OE_N_OUT [*3])
    else $error("data drive dropped too early");
  AST_LOW_BOUNDED: assert property (@(posedge LINK_CLK_IN)
    disable iff (SYS_RST_IN) !SDA_OE_N_OUT |-> ##[1:300] SDA_OE_N_OUT)
    else $error("data line held too long");

  COV_STROBE_ALL: cover property (@(posedge SYS_CLK_IN)
    disable iff (SYS_RST_IN) UPDATE_STROBE_OUT == 4'hf);
  COV_ACK: cover property (@(posedge LINK_CLK_IN)
    disable iff (SYS_RST_IN) $fell(SDA_OE_N_OUT));
  COV_HOLD: cover property (@(posedge SYS_CLK_IN)
    disable iff (SYS_RST_IN) UPDATE_HOLD_IN [*8] ##1 !UPDATE_HOLD_IN);
endmodule : hsdac_slave_sva

bind hsdac_slave hsdac_slave_sva u_sva (
  .SYS_CLK_IN, .SYS_RST_IN, .LINK_CLK_IN, .SCL_IN, .SDA_OUT, .SDA_OE_N_OUT,
  .UPDATE_HOLD_IN, .CHANNEL_HOLDING_REGISTER_OUT,
  .CHANNEL_OUTPUT_REGISTER_OUT, .UPDATE_STROBE_OUT
);

/* test/tb.sv */
// Self-checking bench for the two-wire converter slave
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic rst = 1'b1;
  logic hold = 1'b0;
  logic a_hi = 1'b1;
  logic a_lo = 1'b0;
  logic scl, sda_low, sda_drv, sda_oe_n, ack;
  logic [7:0] rb;
  logic [3:0] strobe;
  hsdac_pkg::hsdac_hold_type [3:0] hq, oq, eh, eo;
  int errors = 0;
  int cmp_count = 0;
  int n_strobe = 0;
  int base;
  wire sda = !sda_low && (sda_oe_n || sda_drv);

  always #5 clk = ~clk;
  always #16 lclk = ~lclk;
  always @(posedge clk) if (strobe[0] === 1'b1) n_strobe <= n_strobe + 1;

  hsdac_slave u_dut (
    .SYS_CLK_IN(clk), .SYS_RST_IN(rst), .LINK_CLK_IN(lclk),
    .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_drv),
    .SDA_OE_N_OUT(sda_oe_n), .ADDRESS_PIN_HI_IN(a_hi),
    .ADDRESS_PIN_LO_IN(a_lo), .UPDATE_HOLD_IN(hold),
    .CHANNEL_HOLDING_REGISTER_OUT(hq), .CHANNEL_OUTPUT_REGISTER_OUT(oq),
    .UPDATE_STROBE_OUT(strobe)
  );
  hsdac_mst u_m (
    .clk_in(lclk), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low)
  );

  task automatic chk(input string what, input logic [13:0] e, g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic xb(input logic [7:0] b, input logic e);
    u_m.wr(b, ack);
    chk("ack", {13'h0, e}, {13'h0, ack});
  endtask : xb

  task automatic check_all();
    for (int i = 0; i < 4; i++) begin
      chk("holding", eh[i], hq[i]);
      chk("output", eo[i], oq[i]);
    end
  endtask : check_all

  task automatic apply(input int ch, ld, input logic [13:0] v);
    eh[ch] = v;
    if (ld == 1) eo[ch] = v;
    if (ld == 2) eo = eh;
    if (ld == 3) begin
      eh = {4{v}};
      eo = eh;
    end
  endtask : apply

  task automatic hs_open(input logic [7:0] ctrl);
    u_m.start();
    xb(8'h0d, 1'b0);
    u_m.start();
    xb(8'h9c, 1'b1);
    xb(ctrl, 1'b1);
  endtask : hs_open

  task automatic pair(input logic [7:0] hi, lo, input int ch, ld,
                      input logic pd);
    logic [13:0] v;
    xb(hi, 1'b1);
    xb(lo, 1'b1);
    v = pd ? {hi[7:6], eh[ch][11:0]} : {2'b00, hi, lo[7:4]};
    apply(ch, ld, v);
    repeat (40) @(posedge clk);
    check_all();
  endtask : pair

  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  initial begin
    #1000000;
    errors++;
    finish_test();
  end

  initial begin
    eh = '0;
    eo = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge lclk);
    check_all();
    hs_open(8'h1c);
    pair(8'hab, 8'hcf, 2, 1, 1'b0);
    pair(8'h12, 8'h3f, 2, 1, 1'b0);
    $display("test data_pairs done");
    for (int l = 0; l < 4; l++) begin
      hs_open({2'b00, l[1:0], 4'h6});
      pair(8'h40 + l[7:0], 8'h70, 3, l, 1'b0);
    end
    $display("test load_modes done");
    hs_open(8'h13);
    pair(8'h80, 8'h00, 1, 1, 1'b1);
    u_m.start();
    xb(8'h9d, 1'b1);
    u_m.rd(1'b1, rb);
    chk("pd byte", {6'h0, eh[1][13:12], 6'h3f}, {6'h0, rb});
    u_m.rd(1'b1, rb);
    chk("high byte", {6'h0, eh[1][11:4]}, {6'h0, rb});
    u_m.rd(1'b0, rb);
    chk("low nibble", {10'h0, eh[1][3:0]}, {10'h0, rb[7:4]});
    u_m.stop();
    $display("test powerdown_readback done");
    u_m.start();
    xb(8'h9e, 1'b0);
    u_m.stop();
    a_lo <= 1'b1;
    u_m.start();
    xb(8'h9c, 1'b0);
    u_m.start();
    xb(8'h9e, 1'b1);
    u_m.stop();
    a_lo <= 1'b0;
    hs_open(8'h10);
    xb(8'h55, 1'b1);
    hs_open(8'h10);
    repeat (40) @(posedge clk);
    check_all();
    pair(8'h55, 8'h60, 0, 1, 1'b0);
    u_m.start();
    xb(8'h9d, 1'b1);
    u_m.rd(1'b1, rb);
    chk("data high byte", {6'h0, eh[0][11:4]}, {6'h0, rb});
    u_m.rd(1'b0, rb);
    chk("data low nibble", {10'h0, eh[0][3:0]}, {10'h0, rb[7:4]});
    u_m.stop();
    $display("test address_abort done");
    @(posedge clk);
    hold <= 1'b1;
    base = n_strobe;
    hs_open(8'h10);
    for (int i = 1; i <= 33; i++) begin
      xb(i[7:0], 1'b1);
      xb(8'h50, 1'b1);
      apply(0, 1, {2'b00, i[7:0], 4'h5});
    end
    xb(8'h22, 1'b0);
    u_m.stop();
    chk("strobes held", 14'h0, 14'(n_strobe - base));
    @(posedge clk);
    hold <= 1'b0;
    repeat (200) @(posedge clk);
    chk("strobes drained", 14'h21, 14'(n_strobe - base));
    check_all();
    $display("test fifo_backpressure done");
    finish_test();
  end
endmodule : tb
